// ---- rtl/pfsw_pkg.sv ----
// constants, types and register map of the program flash self-write controller
package pfsw_pkg;

    // register offsets
    localparam logic [11:0] ADDR_NVM_CONTROL = 12'hfa6;
    localparam logic [11:0] ADDR_EE_DATA     = 12'hfa8;
    localparam logic [11:0] ADDR_EE_ADDR     = 12'hfa9;
    localparam logic [11:0] ADDR_IRQ_MASK    = 12'hfa0;
    localparam logic [11:0] ADDR_IRQ_STATUS  = 12'hfa1;
    localparam logic [11:0] ADDR_TABLE_LATCH = 12'hff5;
    localparam logic [11:0] ADDR_TABLE_PTR   = 12'hff6;

    // nvm_control fields
    localparam int CTL_RD    = 0;
    localparam int CTL_WR    = 1;
    localparam int CTL_WRITE_PERMIT  = 2;
    localparam int CTL_WRITE_ERROR_FLAG = 3;
    localparam int CTL_FREE  = 4;
    localparam int CTL_CONFIG_SPACE_SELECT  = 6;
    localparam int CTL_MEMORY_SPACE_SELECT = 7;
    localparam logic [7:0] CTL_RESET     = 8'h00;
    localparam logic [7:0] CTL_IMPL_MASK = 8'hdf;

    // interrupt status and mask fields
    localparam int IRQ_DONE = 0;
    localparam int IRQ_ERR  = 1;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // memory geometry
    localparam int BYTE_AW      = 8;
    localparam int BANK_AW      = 7;
    localparam int WRITE_BLOCK  = 8;
    localparam int ERASE_BLOCK  = 64;
    localparam logic [5:0] WRITE_LAST = 6'(WRITE_BLOCK - 1);
    localparam logic [5:0] ERASE_LAST = 6'(ERASE_BLOCK - 1);
    localparam logic [7:0] ERASED_BYTE = 8'hff;

    // instruction decode
    localparam logic [15:0] NOP_INSN       = 16'h0000;
    localparam logic [7:0]  INVALID_OPCODE = 8'hff;

    // timing
    localparam int CLK_PERIOD_NS   = 40;
    localparam int PROG_TIME_NS    = 2000000;
    localparam int PROG_CYCLES_DEF = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT,
        ST_COMMIT
    } pfsw_state_t;

    typedef struct packed {
        pfsw_state_t      state;
        logic [7:0]       ctl;
        logic [7:0]       table_latch;
        logic [7:0]       table_ptr;
        logic [7:0]       ee_data;
        logic [7:0]       ee_addr;
        logic [1:0]       irq_st;
        logic [1:0]       irq_mask;
        logic [7:0][7:0]  hold;
        logic [7:0][7:0]  cfg;
        logic [15:0]      timer;
        logic [5:0]       idx;
        logic             tgt_ee;
        logic             tgt_cfg;
        logic             erase;
        logic             tr_pend;
        logic             tr_sel;
        logic             fetch_pend;
        logic [15:0]      fetch_insn;
        logic             fetch_valid;
        logic [7:0]       rdata;
        logic             master_clear_pin_s1;
        logic             master_clear_pin_s2;
    } pfsw_regs_t;

    function automatic logic [15:0] pfsw_insn_filter(input logic [15:0] w);
        return (w[15:8] == INVALID_OPCODE) ? NOP_INSN : w;
    endfunction : pfsw_insn_filter

endpackage : pfsw_pkg

// ---- rtl/pfsw_mem.sv ----
// byte-wide memory with registered read data
`timescale 1ns/10ps
`default_nettype none
module pfsw_mem
    import pfsw_pkg::*;
#(
    parameter int AW = BYTE_AW
) (
    input  wire logic          mclk,
    input  wire logic          we,
    input  wire logic [AW-1:0] addr,
    input  wire logic [7:0]    wdata,
    output var  logic [7:0]    rdata
);
    logic [7:0] mem_r [2**AW];

    always_ff @(posedge mclk) begin
        if (we) begin
            mem_r[addr] <= wdata;
        end
        rdata <= mem_r[addr];
    end
endmodule : pfsw_mem
`default_nettype wire

// ---- rtl/pfsw_ctrl.sv ----
// program flash self-write controller: table ops, programming sequencer, registers
//
// Strobed register access was decided locally.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - flash reads return one byte per address
// - flash write commits eight holding bytes
// - erase clears one 64-byte row
// - no bulk erase reachable from code
// - fetches stall while flash is programmed
// - internal timer ends every program cycle
// - invalid fetched words execute as nop
// - all table transfers pass one latch
// - table writes fill holding registers only
// - table ops use any byte address
// - reset abort sets error, completion clears
// - start bit launches cycle in chosen space
// - start bit set-only, hardware clears it
// - read bit reads eeprom in one cycle
// - read bit ignored when flash selected
module pfsw_ctrl
    import pfsw_pkg::*;
#(
    parameter int PROG_CYC = PROG_CYCLES_DEF
) (
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [11:0] reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    input  wire logic        tbl_rd_op,
    input  wire logic        tbl_wr_op,
    input  wire logic        fetch_req,
    input  wire logic [6:0]  fetch_addr,
    output logic      [15:0] fetch_insn,
    output logic             fetch_valid,
    output logic             fetch_stall,
    input  wire logic        master_clear_pin_n,
    input  wire logic        wdt_reset,
    output logic             irq
);
    localparam logic [15:0] PROG_LAST = 16'(PROG_CYC - 1);

    pfsw_regs_t r;
    pfsw_regs_t n;

    logic             abort;
    logic             commit;
    logic             finish;
    logic             tr_go;
    logic             fetch_go;
    logic             start;
    logic [7:0]       ca;
    logic [5:0]       last_idx;
    logic [6:0]       bank_addr;
    logic [7:0]       bank_wdata;
    logic             even_we;
    logic             odd_we;
    logic             ee_we;
    logic [7:0]       even_rdata;
    logic [7:0]       odd_rdata;
    logic [7:0]       ee_rdata;

    assign commit   = (r.state == ST_COMMIT);
    assign abort    = (r.state != ST_IDLE) && (r.master_clear_pin_s2 || wdt_reset);
    assign fetch_stall = (r.state != ST_IDLE) && !r.tgt_ee;
    assign tr_go    = tbl_rd_op && !fetch_stall && !r.ctl[CTL_CONFIG_SPACE_SELECT];
    assign fetch_go = fetch_req && !fetch_stall && !tbl_rd_op;
    assign start    = reg_wr && (reg_addr == ADDR_NVM_CONTROL) && reg_wdata[CTL_WR]
                      && reg_wdata[CTL_WRITE_PERMIT] && (r.state == ST_IDLE);
    // erase reaches one row only, never the whole array
    assign ca = r.erase ? {r.table_ptr[7:6], r.idx} : {r.table_ptr[7:3], r.idx[2:0]};
    assign last_idx   = r.erase ? ERASE_LAST : WRITE_LAST;
    assign bank_wdata = r.erase ? ERASED_BYTE : r.hold[r.idx[2:0]];
    assign even_we    = commit && !abort && !ca[0];
    assign odd_we     = commit && !abort && ca[0];
    assign ee_we      = (r.state == ST_WAIT) && r.tgt_ee && (r.timer == 16'h0000) && !abort;
    assign bank_addr  = commit ? ca[7:1] : (tr_go ? r.table_ptr[7:1] : fetch_addr);
    assign finish     = !abort && (((r.state == ST_WAIT) && (r.timer == 16'h0000)
                        && (r.tgt_ee || r.tgt_cfg)) || (commit && (r.idx == last_idx)));

    pfsw_mem #(.AW(BANK_AW)) u_even (
        .mclk  (mclk),
        .we    (even_we),
        .addr  (bank_addr),
        .wdata (bank_wdata),
        .rdata (even_rdata)
    );

    pfsw_mem #(.AW(BANK_AW)) u_odd (
        .mclk  (mclk),
        .we    (odd_we),
        .addr  (bank_addr),
        .wdata (bank_wdata),
        .rdata (odd_rdata)
    );

    pfsw_mem #(.AW(BYTE_AW)) u_eeprom (
        .mclk  (mclk),
        .we    (ee_we),
        .addr  (r.ee_addr),
        .wdata (r.ee_data),
        .rdata (ee_rdata)
    );

    always_comb begin
        n = r;
        n.master_clear_pin_s1     = ~master_clear_pin_n;
        n.master_clear_pin_s2     = r.master_clear_pin_s1;
        n.fetch_valid = 1'b0;
        n.fetch_pend  = fetch_go;
        n.tr_pend     = tr_go;
        n.tr_sel      = r.table_ptr[0];
        n.rdata       = 8'h00;
        // read bit lives one cycle
        if (r.ctl[CTL_RD]) begin
            n.ctl[CTL_RD] = 1'b0;
        end
        if (reg_rd) begin
            case (reg_addr)
                ADDR_NVM_CONTROL: n.rdata = r.ctl & CTL_IMPL_MASK;
                ADDR_EE_DATA:     n.rdata = r.ee_data;
                ADDR_EE_ADDR:     n.rdata = r.ee_addr;
                ADDR_IRQ_MASK:    n.rdata = {6'h00, r.irq_mask};
                ADDR_IRQ_STATUS:  n.rdata = {6'h00, r.irq_st};
                ADDR_TABLE_LATCH: n.rdata = r.table_latch;
                ADDR_TABLE_PTR:   n.rdata = r.table_ptr;
                default:          n.rdata = 8'h00;
            endcase
        end
        if (reg_wr) begin
            case (reg_addr)
                ADDR_NVM_CONTROL: begin
                    if (r.state == ST_IDLE) begin
                        n.ctl[CTL_MEMORY_SPACE_SELECT] = reg_wdata[CTL_MEMORY_SPACE_SELECT];
                        n.ctl[CTL_CONFIG_SPACE_SELECT]  = reg_wdata[CTL_CONFIG_SPACE_SELECT];
                        n.ctl[CTL_FREE]  = reg_wdata[CTL_FREE];
                    end
                    n.ctl[CTL_WRITE_PERMIT]  = reg_wdata[CTL_WRITE_PERMIT];
                    n.ctl[CTL_WRITE_ERROR_FLAG] = reg_wdata[CTL_WRITE_ERROR_FLAG];
                    if (reg_wdata[CTL_RD] && !n.ctl[CTL_MEMORY_SPACE_SELECT]) begin
                        n.ctl[CTL_RD] = 1'b1;
                    end
                end
                ADDR_EE_DATA:     n.ee_data = reg_wdata;
                ADDR_EE_ADDR:     n.ee_addr = reg_wdata;
                ADDR_IRQ_MASK:    n.irq_mask = reg_wdata[1:0];
                ADDR_IRQ_STATUS:  n.irq_st = r.irq_st & ~reg_wdata[1:0];
                ADDR_TABLE_LATCH: n.table_latch = reg_wdata;
                ADDR_TABLE_PTR: begin
                    if (!fetch_stall) begin
                        n.table_ptr = reg_wdata;
                    end
                end
                default: begin
                end
            endcase
        end
        // eeprom read data lands in ee_data the cycle after the read bit is high
        if (r.ctl[CTL_RD]) begin
            n.ee_data = ee_rdata;
        end
        // table transfers, one byte each through the latch
        if (r.tr_pend) begin
            n.table_latch = r.tr_sel ? odd_rdata : even_rdata;
        end
        if (tbl_rd_op && !fetch_stall && r.ctl[CTL_CONFIG_SPACE_SELECT]) begin
            n.table_latch = r.cfg[r.table_ptr[2:0]];
        end
        if (tbl_wr_op && !fetch_stall) begin
            n.hold[r.table_ptr[2:0]] = r.table_latch;
        end
        if (r.fetch_pend) begin
            n.fetch_insn  = pfsw_insn_filter({odd_rdata, even_rdata});
            n.fetch_valid = 1'b1;
        end
        if (start) begin
            n.state       = ST_WAIT;
            n.timer       = PROG_LAST;
            n.ctl[CTL_WR] = 1'b1;
            n.tgt_cfg     = n.ctl[CTL_CONFIG_SPACE_SELECT];
            n.tgt_ee      = !n.ctl[CTL_MEMORY_SPACE_SELECT] && !n.ctl[CTL_CONFIG_SPACE_SELECT];
            n.erase       = n.ctl[CTL_FREE] && n.ctl[CTL_MEMORY_SPACE_SELECT] && !n.ctl[CTL_CONFIG_SPACE_SELECT];
            n.idx         = 6'h00;
        end
        case (r.state)
            ST_IDLE: begin
            end
            ST_WAIT: begin
                if (r.timer != 16'h0000) begin
                    n.timer = r.timer - 16'h0001;
                end else if (r.tgt_cfg) begin
                    n.cfg = r.hold;
                end else if (!r.tgt_ee) begin
                    n.state = ST_COMMIT;
                    n.idx   = 6'h00;
                end
            end
            ST_COMMIT: begin
                n.idx = r.idx + 6'h01;
            end
            default: begin
                n.state = ST_IDLE;
            end
        endcase
        if (finish) begin
            n.state              = ST_IDLE;
            n.ctl[CTL_WR]        = 1'b0;
            n.ctl[CTL_WRITE_ERROR_FLAG]     = 1'b0;
            n.irq_st[IRQ_DONE]   = 1'b1;
            if (r.erase) begin
                n.ctl[CTL_FREE] = 1'b0;
            end else if (!r.tgt_ee) begin
                n.hold = {8{ERASED_BYTE}};
            end
        end
        if (abort) begin
            n.state            = ST_IDLE;
            n.ctl[CTL_WR]      = 1'b0;
            n.ctl[CTL_WRITE_ERROR_FLAG]   = 1'b1;
            n.irq_st[IRQ_ERR]  = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            r      <= '0;
            r.ctl  <= CTL_RESET;
            r.hold <= {8{ERASED_BYTE}};
        end else begin
            r <= n;
        end
    end

    assign reg_rdata   = r.rdata;
    assign fetch_insn  = r.fetch_insn;
    assign fetch_valid = r.fetch_valid;
    assign irq         = |(r.irq_st & r.irq_mask);

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    byte_select_a: assert property (
        r.tr_pend |=> r.table_latch == ($past(r.tr_sel) ? $past(odd_rdata) : $past(even_rdata)))
        else $error("table read latched wrong byte");

    write_block_a: assert property (
        commit && !r.erase |-> r.idx <= WRITE_LAST && ca[7:3] == r.table_ptr[7:3])
        else $error("flash write left its 8-byte block");

    erase_row_a: assert property (
        commit && r.erase && finish |-> r.idx == ERASE_LAST && ca[7:6] == r.table_ptr[7:6])
        else $error("row erase length or row wrong");

    stall_busy_a: assert property (
        fetch_stall |=> ##1 !fetch_valid)
        else $error("fetch answered during programming");

    timer_bound_a: assert property (
        r.state == ST_WAIT |-> r.timer <= PROG_LAST)
        else $error("programming timer out of range");

    self_end_a: assert property (
        r.state == ST_WAIT && r.timer == 16'h0000 && !abort |=> r.state != ST_WAIT)
        else $error("programming did not end at timer expiry");

    nop_fill_a: assert property (
        fetch_valid |-> fetch_insn[15:8] != INVALID_OPCODE)
        else $error("invalid instruction word delivered");

    hold_only_a: assert property (
        tbl_wr_op && !fetch_stall |=> r.hold[$past(r.table_ptr[2:0])] == $past(r.table_latch)
        && !even_we && !odd_we)
        else $error("table write missed holding register");

    abort_err_a: assert property (
        abort |=> r.ctl[CTL_WRITE_ERROR_FLAG] && !r.ctl[CTL_WR] && r.state == ST_IDLE)
        else $error("reset abort did not flag error");

    done_clear_a: assert property (
        finish |=> !r.ctl[CTL_WRITE_ERROR_FLAG] && !r.ctl[CTL_WR] && r.irq_st[IRQ_DONE])
        else $error("completion did not clear error");

    wr_busy_a: assert property (
        r.ctl[CTL_WR] == (r.state != ST_IDLE))
        else $error("start bit disagrees with busy state");

    rd_pulse_a: assert property (
        r.ctl[CTL_RD] |-> ##1 !r.ctl[CTL_RD] || $past(reg_wr))
        else $error("read bit not cleared by hardware");

    rd_flash_a: assert property (
        r.ctl[CTL_MEMORY_SPACE_SELECT] |-> !r.ctl[CTL_RD])
        else $error("read bit set with flash selected");

    permit_a: assert property (
        $rose(r.ctl[CTL_WR]) |-> r.ctl[CTL_WRITE_PERMIT])
        else $error("programming started without write permit");

    err_sticky_a: assert property (
        r.ctl[CTL_WRITE_ERROR_FLAG] && !finish && !(reg_wr && reg_addr == ADDR_NVM_CONTROL)
        |=> r.ctl[CTL_WRITE_ERROR_FLAG])
        else $error("write error flag lost without cause");

    start_space_a: assert property (
        start |=> r.state == ST_WAIT
        && r.tgt_ee == !($past(reg_wdata[CTL_MEMORY_SPACE_SELECT]) || $past(reg_wdata[CTL_CONFIG_SPACE_SELECT])))
        else $error("program cycle started in wrong space");

    wr_hold_a: assert property (
        r.ctl[CTL_WR] && !finish && !abort |=> r.ctl[CTL_WR])
        else $error("start bit dropped before completion");

    ee_read_a: assert property (
        r.ctl[CTL_RD] |=> r.ee_data == $past(ee_rdata))
        else $error("eeprom read data not taken");

    cfg_read_a: assert property (
        tbl_rd_op && !fetch_stall && r.ctl[CTL_CONFIG_SPACE_SELECT]
        |=> r.table_latch == $past(r.cfg[r.table_ptr[2:0]]))
        else $error("config table read latched wrong byte");

    erase_pick_a: assert property (
        start |=> r.erase == ($past(reg_wdata[CTL_FREE]) && $past(reg_wdata[CTL_MEMORY_SPACE_SELECT])
        && !$past(reg_wdata[CTL_CONFIG_SPACE_SELECT])))
        else $error("row erase option not taken at start");

    array_busy_a: assert property (
        even_we || odd_we |-> fetch_stall)
        else $error("flash array written while fetches run");

    ptr_locked_a: assert property (
        fetch_stall && reg_wr && reg_addr == ADDR_TABLE_PTR |=> $stable(r.table_ptr))
        else $error("table pointer moved during programming");

    erase_done_c: cover property (commit && r.erase && finish);
    write_done_c: cover property (commit && !r.erase && finish);
    ee_write_c:   cover property (ee_we);
    abort_c:      cover property (abort && commit);
    cfg_write_c:  cover property (r.state == ST_WAIT && r.tgt_cfg && r.timer == 16'h0000);
endmodule : pfsw_ctrl
`default_nettype wire

// ---- tb/pfsw_ctrl_tb_top.sv ----
// self-checking testbench of the program flash self-write controller
`timescale 1ns/10ps
`default_nettype none
module pfsw_ctrl_tb_top;
    import pfsw_pkg::*;
    localparam int         PC      = 20;
    localparam logic [7:0] BLK [8] = '{8'h30, 8'hff, 8'h32, 8'h33, 8'h34, 8'h35, 8'h36, 8'h37};
    logic        mclk               = 1'b0;
    logic        rst                = 1'b1;
    logic [11:0] reg_addr           = 12'h000;
    logic [7:0]  reg_wdata          = 8'h00;
    logic        reg_wr             = 1'b0;
    logic        reg_rd             = 1'b0;
    logic [7:0]  reg_rdata;
    logic        tbl_rd_op          = 1'b0;
    logic        tbl_wr_op          = 1'b0;
    logic        fetch_req          = 1'b0;
    logic [6:0]  fetch_addr         = 7'h00;
    logic [15:0] fetch_insn;
    logic        fetch_valid;
    logic        fetch_stall;
    logic        master_clear_pin_n = 1'b1;
    logic        wdt_reset          = 1'b0;
    logic        irq;
    int          fails              = 0;
    int          num_checks         = 0;

    pfsw_ctrl #(.PROG_CYC(PC)) dut (
        .mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .tbl_rd_op(tbl_rd_op), .tbl_wr_op(tbl_wr_op), .fetch_req(fetch_req),
        .fetch_addr(fetch_addr), .fetch_insn(fetch_insn), .fetch_valid(fetch_valid),
        .fetch_stall(fetch_stall), .master_clear_pin_n(master_clear_pin_n),
        .wdt_reset(wdt_reset), .irq(irq)
    );

    initial begin
        forever #20 mclk = ~mclk;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    task automatic rc(input string nm, input logic [11:0] a, input logic [7:0] m,
                      input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        chk(nm, 16'(exp), 16'(d & m));
    endtask : rc

    task automatic tbl(input bit rdop);
        @(posedge mclk);
        if (rdop) begin
            tbl_rd_op <= 1'b1;
        end else begin
            tbl_wr_op <= 1'b1;
        end
        @(posedge mclk);
        tbl_rd_op <= 1'b0;
        tbl_wr_op <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask : tbl

    task automatic wait_done();
        logic [7:0] d;
        for (int i = 0; i < 100; i++) begin
            rd(ADDR_NVM_CONTROL, d);
            if (d[CTL_WR] === 1'b0) begin
                return;
            end
        end
        chk("completion", 16'h0, 16'h1);
    endtask : wait_done

    task automatic fetch(input logic [6:0] a, input logic [15:0] exp);
        @(posedge mclk);
        fetch_req  <= 1'b1;
        fetch_addr <= a;
        @(posedge mclk);
        fetch_req <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk);
            #1;
            if (fetch_valid === 1'b1) begin
                break;
            end
        end
        chk("fetch valid", 16'h1, 16'(fetch_valid));
        chk("fetch word", exp, fetch_insn);
    endtask : fetch

    initial begin
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        rc("control reset", ADDR_NVM_CONTROL, 8'hff, CTL_RESET);
        rc("mask reset", ADDR_IRQ_MASK, 8'hff, 8'h00);
        wr(12'hfa2, 8'h5a);
        rc("unmapped", 12'hfa2, 8'hff, 8'h00);
        wr(ADDR_EE_ADDR, 8'h05);
        wr(ADDR_EE_DATA, 8'h3c);
        wr(ADDR_NVM_CONTROL, 8'h06);
        chk("eeprom stall", 16'h0, 16'(fetch_stall));
        wait_done();
        rc("done flag", ADDR_IRQ_STATUS, 8'h01, 8'h01);
        wr(ADDR_EE_DATA, 8'h00);
        wr(ADDR_NVM_CONTROL, 8'h01);
        @(posedge mclk);
        rc("eeprom read", ADDR_EE_DATA, 8'hff, 8'h3c);
        rc("read bit", ADDR_NVM_CONTROL, 8'h01, 8'h00);
        wr(ADDR_NVM_CONTROL, 8'h81);
        rc("read on flash", ADDR_NVM_CONTROL, 8'h01, 8'h00);
        wr(ADDR_NVM_CONTROL, 8'h82);
        rc("start unpermitted", ADDR_NVM_CONTROL, 8'h02, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_TABLE_LATCH, BLK[i]);
            wr(ADDR_TABLE_PTR, 8'(8'h10 + i));
            tbl(1'b0);
        end
        wr(ADDR_NVM_CONTROL, 8'h86);
        chk("flash stall", 16'h1, 16'(fetch_stall));
        wr(ADDR_NVM_CONTROL, 8'h84);
        rc("start not cleared", ADDR_NVM_CONTROL, 8'h02, 8'h02);
        wait_done();
        rc("error clear", ADDR_NVM_CONTROL, 8'h08, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_TABLE_PTR, 8'(8'h10 + i));
            tbl(1'b1);
            rc("flash byte", ADDR_TABLE_LATCH, 8'hff, BLK[i]);
        end
        fetch(7'h08, NOP_INSN);
        fetch(7'h09, 16'h3332);
        wr(ADDR_TABLE_PTR, 8'h3f);
        wr(ADDR_NVM_CONTROL, 8'h96);
        wait_done();
        rc("row erase bit", ADDR_NVM_CONTROL, 8'h10, 8'h00);
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_TABLE_PTR, (i == 0) ? 8'h10 : 8'h3f);
            tbl(1'b1);
            rc("erased byte", ADDR_TABLE_LATCH, 8'hff, ERASED_BYTE);
        end
        wr(ADDR_IRQ_MASK, 8'h00);
        chk("irq masked", 16'h0, 16'(irq));
        wr(ADDR_IRQ_MASK, 8'h01);
        chk("irq raised", 16'h1, 16'(irq));
        wr(ADDR_IRQ_STATUS, 8'h01);
        chk("irq cleared", 16'h0, 16'(irq));
        wr(ADDR_IRQ_MASK, 8'h02);
        for (int k = 0; k < 2; k++) begin
            wr(ADDR_NVM_CONTROL, 8'h86);
            repeat ((k == 0) ? 22 : 5) @(posedge mclk);
            if (k == 0) begin
                wdt_reset <= 1'b1;
            end else begin
                master_clear_pin_n <= 1'b0;
            end
            repeat (4) @(posedge mclk);
            wdt_reset          <= 1'b0;
            master_clear_pin_n <= 1'b1;
            rc("abort control", ADDR_NVM_CONTROL, 8'h0a, 8'h08);
            chk("irq error", 16'h1, 16'(irq));
            wr(ADDR_IRQ_STATUS, 8'h02);
            wr(ADDR_NVM_CONTROL, 8'h0e);
            wait_done();
            rc("error cleared", ADDR_NVM_CONTROL, 8'h08, 8'h00);
        end
        wr(ADDR_TABLE_LATCH, 8'h5a);
        wr(ADDR_TABLE_PTR, 8'h02);
        tbl(1'b0);
        wr(ADDR_NVM_CONTROL, 8'h46);
        chk("config stall", 16'h1, 16'(fetch_stall));
        wait_done();
        tbl(1'b1);
        rc("config byte", ADDR_TABLE_LATCH, 8'hff, 8'h5a);
        wr(ADDR_TABLE_PTR, 8'h03);
        tbl(1'b1);
        rc("config blank", ADDR_TABLE_LATCH, 8'hff, ERASED_BYTE);
        report_and_stop();
    end

    initial begin
        #(40 * 20000);
        fails++;
        report_and_stop();
    end
endmodule : pfsw_ctrl_tb_top
`default_nettype wire
